// ### pkg/shm_pkg.sv
// shared constants and types of the sensor hub receive mode control
package shm_pkg;
  localparam int NPORT = 4;
  localparam int CLK_HZ = 50_000_000;
  // register offsets
  localparam logic [7:0] ADDR_FWD_EN = 8'h20;
  localparam logic [7:0] ADDR_CSI_CTL = 8'h33;
  localparam logic [7:0] ADDR_PAGE = 8'h4C;
  localparam logic [7:0] ADDR_BC_RATE = 8'h58;
  localparam logic [7:0] ADDR_SETUP = 8'h6D;
  localparam logic [7:0] ADDR_RAW_ID = 8'h70;
  localparam logic [7:0] ADDR_REMAP = 8'h72;
  localparam logic [7:0] ADDR_STATUS = 8'h74;
  // setup field positions
  localparam int SETUP_SYNC_BIT = 2;
  localparam int SETUP_DIV_BIT = 3;
  // values after reset, data type codes and strap wait count
  localparam logic [3:0] FWD_EN_RST = 4'hF;
  localparam logic [1:0] LANES_RST = 2'h3;
  localparam logic [7:0] REMAP_RST = 8'hE4;
  localparam logic [5:0] DT_RAW8 = 6'h2A;
  localparam logic [5:0] DT_RAW12 = 6'h2C;
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  // back channel rate codes and bit periods
  localparam logic [2:0] BC_CODE_2M5 = 3'h0;
  localparam logic [2:0] BC_CODE_10M = 3'h2;
  localparam logic [2:0] BC_CODE_50M = 3'h6;
  localparam int BC_BPS_2M5 = 2_500_000;
  localparam int BC_BPS_10M = 10_000_000;
  localparam int BC_BPS_50M = 50_000_000;
  localparam int BC_CYC_2M5 = CLK_HZ / BC_BPS_2M5;
  localparam int BC_CYC_10M = CLK_HZ / BC_BPS_10M;
  localparam int BC_CYC_50M = CLK_HZ / BC_BPS_50M;
  localparam logic [3:0] BC_FRAME_BITS = 4'hA;
  // framing pattern and field positions of the 40 and 28 bit frames
  localparam logic [1:0] FRAME_SYNC = 2'h1;
  localparam int CSI_SYNC_LSB = 38;
  localparam int CSI_VC_LSB = 36;
  localparam int CSI_DT_LSB = 30;
  localparam int CSI_DATA_LSB = 18;
  localparam int CSI_HS_BIT = 17;
  localparam int CSI_VS_BIT = 16;
  localparam int CSI_I2C_LSB = 8;
  localparam int CSI_DIAG_LSB = 2;
  localparam int CSI_I2CV_BIT = 1;
  localparam int RAW_SYNC_LSB = 26;
  localparam int RAW_DATA_LSB = 14;
  localparam int RAW10_DATA_LSB = 16;
  localparam int RAW_HS_BIT = 13;
  localparam int RAW_VS_BIT = 12;
  localparam int RAW_I2C_LSB = 4;
  localparam int RAW_I2CV_BIT = 3;
  localparam int RAW_DIAG_LSB = 1;
  // line rate and clock multipliers
  localparam logic [7:0] LINE_MULT_SYNC = 8'hA0;
  localparam logic [7:0] LINE_MULT_NONSYNC = 8'h50;
  localparam logic [7:0] LINE_MULT_RAW = 8'h1C;
  localparam logic [7:0] LINE_MULT_RAW12HF = 8'h38;
  localparam logic [1:0] LINE_DEN_RAW12HF = 2'h3;
  localparam logic [1:0] LINE_DEN_RAW10 = 2'h2;
  localparam logic [2:0] PCLK_MULT_SYNC = 3'h4;
  localparam logic [2:0] PCLK_MULT_NONSYNC = 3'h2;
  localparam logic [1:0] BC_MULT_SYNC = 2'h2;

  typedef enum logic [1:0] {
    SHM_MODE_CSI, SHM_MODE_RAW12LF, SHM_MODE_RAW12HF, SHM_MODE_RAW10
  } shm_mode_t;

  typedef enum logic [1:0] {SHM_REF_HUB, SHM_REF_SER, SHM_REF_PIX} shm_ref_t;

  typedef struct packed {
    shm_ref_t ref_src;
    logic [7:0] line_num;
    logic [1:0] line_den;
    logic [2:0] pclk_num;
    logic [1:0] bc_num;
  } shm_rate_t;

  typedef struct packed {
    logic [1:0] port;
    logic [1:0] vc;
    logic [5:0] dt;
    logic hs;
    logic vs;
    logic [11:0] data;
  } shm_pix_t;
endpackage

// ### hdl/shm_rx_decode.sv
// frame decoder of one receive port with a one-word holding stage
`timescale 1ns/1ps
module shm_rx_decode (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic flush,
  input wire shm_pkg::shm_mode_t mode,
  input wire logic [1:0] port_id,
  input wire logic [7:0] vc_remap,
  input wire logic [7:0] raw_id,
  input wire logic [39:0] frame,
  input wire logic frame_valid,
  output logic frame_ready,
  output logic out_valid,
  input wire logic out_ready,
  output shm_pkg::shm_pix_t out_word,
  output logic [7:0] i2c_byte,
  output logic i2c_stb,
  output logic err_stb,
  output logic [3:0] diag
);
  typedef struct packed {
    logic rdy;
    logic hold;
    shm_pkg::shm_pix_t word;
    logic [7:0] i2c;
    logic i2c_stb;
    logic err;
    logic [3:0] diag;
  } shm_dec_st_t;

  shm_dec_st_t st;
  shm_dec_st_t next_st;
  shm_pkg::shm_pix_t dec;
  logic good;
  logic csi;

  // decode the frame by mode, then update the holding stage
  always_comb begin
    csi = (mode == shm_pkg::SHM_MODE_CSI);
    dec = '0;
    dec.port = port_id;
    next_st = st;
    next_st.i2c_stb = 1'b0;
    next_st.err = 1'b0;
    if (csi) begin
      good = (frame[shm_pkg::CSI_SYNC_LSB +: 2] == shm_pkg::FRAME_SYNC) &&
        !(^frame);
      dec.vc = vc_remap[{frame[shm_pkg::CSI_VC_LSB +: 2], 1'b0} +: 2];
      dec.dt = frame[shm_pkg::CSI_DT_LSB +: 6];
      dec.data = frame[shm_pkg::CSI_DATA_LSB +: 12];
      dec.hs = frame[shm_pkg::CSI_HS_BIT];
      dec.vs = frame[shm_pkg::CSI_VS_BIT];
    end else begin
      good = (frame[shm_pkg::RAW_SYNC_LSB +: 2] == shm_pkg::FRAME_SYNC) &&
        !(^frame[27:0]);
      dec.vc = raw_id[7:6];
      dec.dt = raw_id[5:0];
      dec.hs = frame[shm_pkg::RAW_HS_BIT];
      dec.vs = frame[shm_pkg::RAW_VS_BIT];
      if (mode == shm_pkg::SHM_MODE_RAW10) begin
        dec.data = {2'h0, frame[shm_pkg::RAW10_DATA_LSB +: 10]};
      end else begin
        dec.data = frame[shm_pkg::RAW_DATA_LSB +: 12];
      end
      if (raw_id[5:0] == shm_pkg::DT_RAW8) begin
        dec.data = {4'h0, dec.data[7:0]};
      end
    end
    if (out_ready && st.hold) begin
      next_st.hold = 1'b0;
    end
    if (frame_valid && st.rdy) begin
      if (!good) begin
        next_st.err = 1'b1;
      end else begin
        next_st.hold = 1'b1;
        next_st.word = dec;
        next_st.i2c_stb = csi ? frame[shm_pkg::CSI_I2CV_BIT] :
          frame[shm_pkg::RAW_I2CV_BIT];
        next_st.i2c = csi ? frame[shm_pkg::CSI_I2C_LSB +: 8] :
          frame[shm_pkg::RAW_I2C_LSB +: 8];
        next_st.diag = csi ? frame[shm_pkg::CSI_DIAG_LSB +: 4] :
          {2'h0, frame[shm_pkg::RAW_DIAG_LSB +: 2]};
      end
    end
    if (flush) begin
      next_st.hold = 1'b0;
    end
    next_st.rdy = !next_st.hold && !flush;
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
      st.rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign frame_ready = st.rdy;
  assign out_valid = st.hold;
  assign out_word = st.word;
  assign i2c_byte = st.i2c;
  assign i2c_stb = st.i2c_stb;
  assign err_stb = st.err;
  assign diag = st.diag;
endmodule

// ### hdl/shm_buf2.sv
// two-entry buffer between port arbitration and the csi-2 packer
`timescale 1ns/1ps
module shm_buf2 (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire shm_pkg::shm_pix_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output shm_pkg::shm_pix_t out_word
);
  typedef struct packed {
    shm_pkg::shm_pix_t [1:0] slot;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic in_rdy;
    logic out_v;
  } shm_buf_st_t;

  shm_buf_st_t st;
  shm_buf_st_t next_st;
  logic push;
  logic pop;

  // push and pop, full and empty kept as flops
  always_comb begin
    next_st = st;
    push = in_valid && st.in_rdy;
    pop = out_ready && st.out_v;
    if (push) begin
      next_st.slot[st.wp] = in_word;
      next_st.wp = !st.wp;
    end
    if (pop) begin
      next_st.rp = !st.rp;
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
    next_st.in_rdy = (next_st.cnt != 2'h2);
    next_st.out_v = (next_st.cnt != 2'h0);
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
      st.in_rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = st.in_rdy;
  assign out_valid = st.out_v;
  assign out_word = st.slot[st.rp];
endmodule

// ### hdl/shm_rx_mode_ctl.sv
// sensor hub receive mode control: registers, strap, forwarding, back channel
`timescale 1ns/1ps

module shm_rx_mode_ctl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] mode_strap,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [3:0][39:0] rx_frame,
  input wire logic [3:0] rx_frame_valid,
  output logic [3:0] rx_frame_ready,
  output logic [3:0][7:0] fwd_i2c_byte,
  output logic [3:0] fwd_i2c_stb,
  input wire logic [7:0] bc_byte,
  input wire logic [1:0] bc_port,
  input wire logic bc_valid,
  output logic [3:0] bc_accept,
  output logic [3:0] bc_line,
  output logic csi_valid,
  input wire logic csi_ready,
  output shm_pkg::shm_pix_t csi_word,
  output logic [1:0] csi_lane_count,
  output shm_pkg::shm_rate_t [3:0] port_rate
);
  typedef struct packed {
    logic [2:0] strap_m;
    logic [2:0] strap_s;
    logic [1:0] strap_wait;
    logic strap_done;
    logic [1:0] page;
    logic [2:0] bc_rate;
    logic [1:0] lanes;
    logic [3:0] fwd_en;
    logic [3:0][3:0] setup;
    logic [3:0][7:0] raw_id;
    logic [3:0][7:0] remap;
    logic [3:0][3:0] err_cnt;
    logic [3:0] flush;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] rr;
    logic [4:0] bc_div;
    logic [3:0][9:0] bc_sh;
    logic [3:0][3:0] bc_cnt;
    logic [3:0] bc_acc;
    logic [3:0] bc_out;
    shm_pkg::shm_rate_t [3:0] rate;
  } shm_ctl_st_t;

  shm_ctl_st_t st;
  shm_ctl_st_t next_st;
  logic [3:0] dec_valid;
  logic [3:0] dec_ready;
  logic [3:0] dec_err;
  logic [3:0][3:0] dec_diag;
  shm_pkg::shm_pix_t [3:0] dec_word;
  logic buf_valid;
  logic buf_ready;
  shm_pkg::shm_pix_t buf_word;
  logic [1:0] pick;
  logic [1:0] idx;
  logic found;
  logic tick;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // rate settings of one port from its setup field
  function automatic shm_pkg::shm_rate_t rate_of(input logic [3:0] s);
    rate_of = '0;
    rate_of.line_den = 2'h1;
    case (shm_pkg::shm_mode_t'(s[1:0]))
      shm_pkg::SHM_MODE_CSI: begin
        if (s[shm_pkg::SETUP_SYNC_BIT]) begin
          rate_of.ref_src = shm_pkg::SHM_REF_HUB;
          rate_of.line_num = shm_pkg::LINE_MULT_SYNC;
          rate_of.pclk_num = shm_pkg::PCLK_MULT_SYNC;
          rate_of.bc_num = shm_pkg::BC_MULT_SYNC;
        end else begin
          rate_of.ref_src = shm_pkg::SHM_REF_SER;
          rate_of.line_num = shm_pkg::LINE_MULT_NONSYNC;
          rate_of.pclk_num = s[shm_pkg::SETUP_DIV_BIT] ? 3'h1 :
            shm_pkg::PCLK_MULT_NONSYNC;
        end
      end
      shm_pkg::SHM_MODE_RAW12HF: begin
        rate_of.ref_src = shm_pkg::SHM_REF_PIX;
        rate_of.line_num = shm_pkg::LINE_MULT_RAW12HF;
        rate_of.line_den = shm_pkg::LINE_DEN_RAW12HF;
        rate_of.pclk_num = 3'h1;
      end
      shm_pkg::SHM_MODE_RAW12LF: begin
        rate_of.ref_src = shm_pkg::SHM_REF_PIX;
        rate_of.line_num = shm_pkg::LINE_MULT_RAW;
        rate_of.pclk_num = 3'h1;
      end
      default: begin
        rate_of.ref_src = shm_pkg::SHM_REF_PIX;
        rate_of.line_num = shm_pkg::LINE_MULT_RAW;
        rate_of.line_den = shm_pkg::LINE_DEN_RAW10;
        rate_of.pclk_num = 3'h1;
      end
    endcase
  endfunction

  // back channel bit period in cycles, minus one
  function automatic logic [4:0] bc_period(input logic [2:0] code);
    if (code == shm_pkg::BC_CODE_50M) begin
      bc_period = 5'(shm_pkg::BC_CYC_50M - 1);
    end else if (code == shm_pkg::BC_CODE_10M) begin
      bc_period = 5'(shm_pkg::BC_CYC_10M - 1);
    end else begin
      bc_period = 5'(shm_pkg::BC_CYC_2M5 - 1);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // per-port decoders and output buffer

  for (genvar g = 0; g < shm_pkg::NPORT; g++) begin : g_port
    shm_rx_decode u_dec (
      .mclk(mclk),
      .rst_n(rst_n),
      .flush(st.flush[g]),
      .mode(shm_pkg::shm_mode_t'(st.setup[g][1:0])),
      .port_id(2'(g)),
      .vc_remap(st.remap[g]),
      .raw_id(st.raw_id[g]),
      .frame(rx_frame[g]),
      .frame_valid(rx_frame_valid[g]),
      .frame_ready(rx_frame_ready[g]),
      .out_valid(dec_valid[g]),
      .out_ready(dec_ready[g]),
      .out_word(dec_word[g]),
      .i2c_byte(fwd_i2c_byte[g]),
      .i2c_stb(fwd_i2c_stb[g]),
      .err_stb(dec_err[g]),
      .diag(dec_diag[g])
    );
  end

  shm_buf2 u_buf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(buf_valid),
    .in_ready(buf_ready),
    .in_word(buf_word),
    .out_valid(csi_valid),
    .out_ready(csi_ready),
    .out_word(csi_word)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.flush = 4'h0;
    // strap pin through two flops, loaded once after reset
    next_st.strap_m = mode_strap;
    next_st.strap_s = st.strap_m;
    if (!st.strap_done) begin
      if (st.strap_wait == shm_pkg::STRAP_WAIT) begin
        next_st.strap_done = 1'b1;
        for (int i = 0; i < shm_pkg::NPORT; i++) begin
          next_st.setup[i] = {1'b0, st.strap_s[2] &&
            (st.strap_s[1:0] == 2'h0), st.strap_s[1:0]};
        end
        next_st.bc_rate = (st.strap_s[1:0] == 2'h0) ?
          shm_pkg::BC_CODE_50M : shm_pkg::BC_CODE_2M5;
      end else begin
        next_st.strap_wait = st.strap_wait + 2'h1;
      end
    end
    // register writes
    if (reg_wr) begin
      if (reg_addr == shm_pkg::ADDR_PAGE) begin
        next_st.page = reg_wdata[1:0];
      end else if (reg_addr == shm_pkg::ADDR_FWD_EN) begin
        next_st.fwd_en = reg_wdata[3:0];
      end else if (reg_addr == shm_pkg::ADDR_CSI_CTL) begin
        next_st.lanes = reg_wdata[1:0];
      end else if (reg_addr == shm_pkg::ADDR_BC_RATE) begin
        next_st.bc_rate = reg_wdata[2:0];
      end else if (reg_addr == shm_pkg::ADDR_SETUP) begin
        next_st.setup[st.page] = reg_wdata[3:0];
      end else if (reg_addr == shm_pkg::ADDR_RAW_ID) begin
        next_st.raw_id[st.page] = reg_wdata;
      end else if (reg_addr == shm_pkg::ADDR_REMAP) begin
        next_st.remap[st.page] = reg_wdata;
      end else if (reg_addr == shm_pkg::ADDR_STATUS) begin
        next_st.err_cnt[st.page] = 4'h0;
      end
    end
    // register reads, answered one cycle later
    if (reg_rd) begin
      next_st.rvalid = 1'b1;
      if (reg_addr == shm_pkg::ADDR_PAGE) begin
        next_st.rdata = {6'h00, st.page};
      end else if (reg_addr == shm_pkg::ADDR_FWD_EN) begin
        next_st.rdata = {4'h0, st.fwd_en};
      end else if (reg_addr == shm_pkg::ADDR_CSI_CTL) begin
        next_st.rdata = {6'h00, st.lanes};
      end else if (reg_addr == shm_pkg::ADDR_BC_RATE) begin
        next_st.rdata = {5'h00, st.bc_rate};
      end else if (reg_addr == shm_pkg::ADDR_SETUP) begin
        next_st.rdata = {4'h0, st.setup[st.page]};
      end else if (reg_addr == shm_pkg::ADDR_RAW_ID) begin
        next_st.rdata = st.raw_id[st.page];
      end else if (reg_addr == shm_pkg::ADDR_REMAP) begin
        next_st.rdata = st.remap[st.page];
      end else if (reg_addr == shm_pkg::ADDR_STATUS) begin
        next_st.rdata = {dec_diag[st.page], st.err_cnt[st.page]};
      end else begin
        next_st.rdata = 8'h00;
      end
    end
    // per-port mode change, error counts and rates
    for (int i = 0; i < shm_pkg::NPORT; i++) begin
      next_st.flush[i] = (next_st.setup[i][1:0] != st.setup[i][1:0]);
      if (dec_err[i] && st.err_cnt[i] != 4'hF) begin
        next_st.err_cnt[i] = next_st.err_cnt[i] + 4'h1;
      end
      next_st.rate[i] = rate_of(st.setup[i]);
    end
    // round-robin forwarding of the ports enabled in fwd_en into the one output
    pick = st.rr;
    idx = st.rr;
    found = 1'b0;
    for (int k = 0; k < shm_pkg::NPORT; k++) begin
      idx = idx + 2'h1;
      if (!found && dec_valid[idx] && st.fwd_en[idx]) begin
        pick = idx;
        found = 1'b1;
      end
    end
    buf_valid = found;
    buf_word = dec_word[pick];
    dec_ready = 4'h0;
    if (found && buf_ready) begin
      dec_ready[pick] = 1'b1;
      next_st.rr = pick;
    end
    // back channel: one bit clock for all ports, idle ones
    tick = (st.bc_div == 5'h00);
    next_st.bc_div = tick ? bc_period(st.bc_rate) : st.bc_div - 5'h01;
    for (int i = 0; i < shm_pkg::NPORT; i++) begin
      if (tick) begin
        if (st.bc_cnt[i] != 4'h0) begin
          next_st.bc_out[i] = st.bc_sh[i][0];
          next_st.bc_sh[i] = {1'b1, st.bc_sh[i][9:1]};
          next_st.bc_cnt[i] = st.bc_cnt[i] - 4'h1;
        end else begin
          next_st.bc_out[i] = 1'b1;
        end
      end
      if (bc_valid && bc_port == 2'(i) && st.bc_acc[i]) begin
        next_st.bc_sh[i] = {1'b1, bc_byte, 1'b0};
        next_st.bc_cnt[i] = shm_pkg::BC_FRAME_BITS;
      end
      next_st.bc_acc[i] = (next_st.bc_cnt[i] == 4'h0);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
      st.fwd_en <= shm_pkg::FWD_EN_RST;
      st.lanes <= shm_pkg::LANES_RST;
      st.bc_acc <= 4'hF;
      st.bc_out <= 4'hF;
      for (int i = 0; i < shm_pkg::NPORT; i++) begin
        st.remap[i] <= shm_pkg::REMAP_RST;
        st.raw_id[i] <= {2'(i), shm_pkg::DT_RAW12};
      end
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign bc_accept = st.bc_acc;
  assign bc_line = st.bc_out;
  assign csi_lane_count = st.lanes;
  assign port_rate = st.rate;
endmodule

// ### verif/shm_rx_mode_ctl_sva.sv
// concurrent checks on the receive mode control ports
`timescale 1ns/1ps
module shm_rx_mode_ctl_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic [3:0] rx_frame_valid,
  input wire logic [3:0] rx_frame_ready,
  input wire logic [3:0] fwd_i2c_stb,
  input wire logic [1:0] bc_port,
  input wire logic bc_valid,
  input wire logic [3:0] bc_accept,
  input wire logic [3:0] bc_line,
  input wire logic csi_valid,
  input wire logic csi_ready,
  input wire shm_pkg::shm_pix_t csi_word,
  input wire shm_pkg::shm_rate_t [3:0] port_rate
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rd_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  take_drop_a: assert property (rx_frame_valid[0] && rx_frame_ready[0]
    |=> !rx_frame_ready[0])
    else $error("port kept ready after take");
  i2c_cause_a: assert property (fwd_i2c_stb[0]
    |-> $past(rx_frame_valid[0] && rx_frame_ready[0]))
    else $error("i2c strobe without frame");
  csi_hold_a: assert property (csi_valid && !csi_ready
    |=> csi_valid && $stable(csi_word))
    else $error("output word dropped under stall");
  bc_take_a: assert property (bc_valid && bc_port == 2'h3 && bc_accept[3]
    |=> !bc_accept[3])
    else $error("back channel offer not taken");
  bc_idle_a: assert property (bc_accept[3] |-> bc_line[3])
    else $error("idle back channel not high");
  sync_rate_a: assert property ($past(rst_n)
    && port_rate[0].ref_src == shm_pkg::SHM_REF_HUB
    |-> port_rate[0].line_num == shm_pkg::LINE_MULT_SYNC
    && port_rate[0].pclk_num == 3'h4 && port_rate[0].bc_num == 2'h2)
    else $error("synchronous rates wrong");
  hf_rate_a: assert property (port_rate[0].line_den == 2'h3
    |-> port_rate[0].line_num == shm_pkg::LINE_MULT_RAW12HF)
    else $error("high frequency line rate wrong");
  raw10_rate_a: assert property (port_rate[0].line_den == 2'h2
    |-> port_rate[0].line_num == shm_pkg::LINE_MULT_RAW)
    else $error("ten bit line rate wrong");
endmodule

bind shm_rx_mode_ctl shm_rx_mode_ctl_sva u_sva (.mclk(mclk), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
  .rx_frame_valid(rx_frame_valid), .rx_frame_ready(rx_frame_ready),
  .fwd_i2c_stb(fwd_i2c_stb), .bc_port(bc_port), .bc_valid(bc_valid),
  .bc_accept(bc_accept), .bc_line(bc_line), .csi_valid(csi_valid),
  .csi_ready(csi_ready), .csi_word(csi_word), .port_rate(port_rate));

// ### verif/shm_ser_model.sv
// remote serializer: builds one link frame per request and holds it
`timescale 1ns/1ps
module shm_ser_model (
  input wire logic mclk,
  input wire logic req,
  input wire logic raw,
  input wire logic [1:0] vc,
  input wire logic [5:0] dt,
  input wire logic [11:0] px,
  input wire logic [7:0] i2c,
  input wire logic bad,
  input wire logic ready,
  output logic [39:0] frame,
  output logic valid
);
  logic [39:0] f = 40'h0;
  initial valid = 1'b0;
  // a released frame shows the inverse of the last one
  assign frame = valid ? f : ~f;
  // sync lines stay quiet, frames carry even parity
  always @(posedge mclk) begin
    if (valid && ready)
      valid <= 1'b0;
    else if (req) begin
      valid <= 1'b1;
      if (raw)
        f <= par({12'h0, 2'b01, px, 2'b00, i2c, 1'b1, 3'h0});
      else
        f <= par({2'b01, vc, dt, px, 2'b00, i2c, 6'h0, 2'b10});
    end
  end
  function automatic logic [39:0] par(input logic [39:0] x);
    par = {x[39:1], bad ^ (^x[39:1])};
  endfunction
endmodule

// ### verif/shm_rx_mode_ctl_test.sv
// self-checking bench for the receive mode control block
`timescale 1ns/1ps
module shm_rx_mode_ctl_test;
  logic mclk, rst_n, reg_wr, reg_rd, reg_rvalid, bc_valid, csi_valid;
  logic csi_ready, hold, raw, bad, m10;
  logic [2:0] strap;
  logic [3:0][7:0] fi;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, bc_byte, i2c, map, rid;
  logic [1:0] bc_port, vc, lanes;
  logic [5:0] dt;
  logic [11:0] px;
  logic [8:0] bcv;
  logic [3:0] req, mv, rdy, line;
  logic [3:0][39:0] fr;
  shm_pkg::shm_pix_t csi_word;
  shm_pkg::shm_rate_t [3:0] rate;
  shm_pkg::shm_pix_t cq[$];
  logic [7:0] rq[$];
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [15:0] rr [8] = '{16'h200f, 16'h3303, 16'h4c00, 16'h5806,
    16'h6d00, 16'h72e4, 16'h702c, 16'h0100};
  logic [12:0] rt [6] = '{13'h140c, 13'h0a0a, 13'h0a09, 13'h0388,
    13'h0718, 13'h0390};
  logic [3:0] su [6] = '{4'h4, 4'h0, 4'h8, 4'h1, 4'h2, 4'h3};

  shm_rx_mode_ctl uut (.mclk(mclk), .rst_n(rst_n), .mode_strap(strap),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rx_frame(fr), .rx_frame_valid(mv), .rx_frame_ready(rdy),
    .fwd_i2c_byte(fi), .fwd_i2c_stb(), .bc_byte(bc_byte),
    .bc_port(bc_port), .bc_valid(bc_valid), .bc_accept(),
    .bc_line(line), .csi_valid(csi_valid), .csi_ready(csi_ready),
    .csi_word(csi_word), .csi_lane_count(lanes), .port_rate(rate));
  for (genvar p = 0; p < 4; p++) begin : g_ser
    shm_ser_model m (.mclk(mclk), .req(req[p]), .raw(raw), .vc(vc),
      .dt(dt), .px(px), .i2c(i2c), .ready(rdy[p]), .frame(fr[p]),
      .valid(mv[p]), .bad(bad));
  end

  ////////////////////////////////////////////////////////////////////////
  // clock, random sink stalls, answer monitors and watchdog
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    #2;
    csi_ready = !hold && ($urandom % 3 != 0);
  end
  always @(posedge mclk) begin
    if (reg_rvalid === 1'b1) check("reg", reg_rdata, rq.pop_front());
    if (csi_valid === 1'b1 && csi_ready)
      check("csi", csi_word, cq.pop_front());
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task tick;
    @(posedge mclk);
    #2;
  endtask
  task automatic check(input string nm, input logic [23:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    tick;
  endtask
  task automatic rd(input logic [7:0] a, e);
    rq.push_back(e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    tick;
  endtask
  // one random frame on port p, expected word noted first
  task automatic send(input logic [1:0] p, input logic r);
    shm_pkg::shm_pix_t e;
    vc = 2'($urandom);
    dt = 6'($urandom);
    px = 12'($urandom);
    i2c = 8'($urandom);
    raw = r;
    e.port = p;
    e.vc = r ? rid[7:6] : map[2*vc +: 2];
    e.dt = r ? rid[5:0] : dt;
    e.hs = 1'b0;
    e.vs = 1'b0;
    e.data = (r && rid[5:0] == shm_pkg::DT_RAW8) ? {4'h0, px[7:0]} : px;
    if (r && m10) e.data = {2'h0, px[11:2]};
    cq.push_back(e);
    req[p] = 1'b1;
    tick;
    req[p] = 1'b0;
    for (int i = 0; i < 200 && mv[p]; i++) tick;
    check("i2c", fi[p], {16'h0, i2c});
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h089d_c6ce));
    {rst_n, reg_wr, reg_rd, bc_valid, hold, raw} = 6'h0;
    {reg_addr, reg_wdata, bc_byte, bc_port, req, i2c} = 38'h0;
    {vc, dt, px, csi_ready, rid} = 29'h0;
    {bad, m10, strap} = 5'h0;
    map = 8'he4;
    repeat (16) tick;
    rst_n = 1'b1;
    repeat (4) tick;
    foreach (rr[i]) rd(rr[i][15:8], rr[i][7:0]);
    wr(8'h33, 8'h01);
    check("lanes", lanes, 24'h1);
    wr(8'h58, 8'h02);
    rd(8'h58, 8'h02);
    wr(8'h72, 8'h1b);
    for (int p = 0; p < 4; p++) begin
      map = (p == 0) ? 8'h1b : 8'he4;
      send(2'(p), 1'b0);
    end
    foreach (su[i]) begin
      wr(8'h6d, {4'h0, su[i]});
      check("rate", {rate[0].line_num, rate[0].line_den,
        i < 3 ? rate[0].pclk_num : 3'h0}, {11'h0, rt[i]});
      rd(8'h6d, {4'h0, su[i]});
    end
    wr(8'h58, 8'h00);
    wr(8'h6d, 8'h01);
    rid = 8'h2c;
    send(2'h0, 1'b1);
    wr(8'h6d, 8'h03);
    m10 = 1'b1;
    send(2'h0, 1'b1);
    m10 = 1'b0;
    wr(8'h70, 8'haa);
    wr(8'h6d, 8'h01);
    rid = 8'haa;
    send(2'h0, 1'b1);
    send(2'h1, 1'b0);
    // one frame with broken parity on port 1 must only count an error
    bad = 1'b1;
    req[1] = 1'b1;
    tick;
    req[1] = 1'b0;
    bad = 1'b0;
    for (int i = 0; i < 200 && mv[1]; i++) tick;
    repeat (2) tick;
    wr(8'h4c, 8'h01);
    rd(8'h74, 8'h01);
    wr(8'h74, 8'h00);
    rd(8'h74, 8'h00);
    wr(8'h4c, 8'h00);
    wr(8'h20, 8'h0e);
    send(2'h0, 1'b1);
    check("fwd_off", rdy[0], 24'h0);
    wr(8'h20, 8'h0f);
    repeat (30) tick;
    hold = 1'b1;
    repeat (3) send(2'h2, 1'b0);
    repeat (4) tick;
    check("stall", rdy[2], 24'h0);
    hold = 1'b0;
    wr(8'h58, 8'h06);
    bc_byte = 8'($urandom);
    bc_port = 2'h3;
    bc_valid = 1'b1;
    tick;
    bc_valid = 1'b0;
    for (int i = 0; i < 50 && line[3]; i++) tick;
    for (int i = 0; i < 9; i++) begin
      tick;
      bcv[i] = line[3];
    end
    check("bc", {15'h0, bcv}, {15'h0, 1'b1, bc_byte});
    for (int i = 0; i < 500 && cq.size() > 0; i++) tick;
    check("drain", 24'(cq.size()), 24'h0);
    // second reset with another strap level reloads the mode fields
    strap = 3'h6;
    rst_n = 1'b0;
    repeat (2) tick;
    rst_n = 1'b1;
    repeat (4) tick;
    rd(8'h6d, 8'h02);
    rd(8'h58, 8'h00);
    check("strap_rate", {rate[0].line_num, rate[0].line_den},
      24'h0e3);
    test_done;
  end
endmodule
